// file: design/osc_autoselect.sv
// Oscillator sub-band autoselect state machine; the band comes from the configuration.
// Assumes i_tune_code is already synchronised and i_xtal_tick is a
// one-cycle pulse per crystal period.
`timescale 1ns/1ps
`default_nettype none
`include "tuner_osc_cfg.svh"
module osc_autoselect
    import tuner_osc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_xtal_tick,
    input wire logic i_enable,
    input wire logic i_start,
    input wire logic i_start_from_current,
    input wire logic [1:0] i_cfg_band,
    input wire logic [3:0] i_cfg_sub,
    input wire logic [15:0] i_wait_ticks,
    input wire logic [2:0] i_tune_code,
    output logic [1:0] o_band,
    output logic [3:0] o_sub_band,
    output logic o_busy,
    output logic o_done
);
    autosel_state_t state_r;
    autosel_state_t state_nxt;
    logic [15:0] cnt_r;
    logic wait_end;
    localparam logic [7:0] RST_BAND = `TOC_RST_BAND;

    assign wait_end = i_xtal_tick && (cnt_r == i_wait_ticks - 16'h0001);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (i_enable && i_start) state_nxt = ST_WAIT;
            ST_WAIT: begin
                if (!i_enable) state_nxt = ST_IDLE;
                else if (!i_start && wait_end) state_nxt = ST_CHECK;
            end
            ST_CHECK: begin
                if (!i_enable) state_nxt = ST_IDLE;
                else if (i_start) state_nxt = ST_WAIT;
                else if (i_tune_code == `TUNE_LOW && o_sub_band != `SUB_MIN)
                    state_nxt = ST_WAIT;
                else if (i_tune_code == `TUNE_HIGH && o_sub_band != `SUB_MAX)
                    state_nxt = ST_WAIT;
                else state_nxt = ST_DONE;
            end
            ST_DONE: begin
                if (!i_enable) state_nxt = ST_IDLE;
                else if (i_start) state_nxt = ST_WAIT;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            state_r <= state_nxt;
            o_busy <= (state_nxt == ST_WAIT) || (state_nxt == ST_CHECK);
            o_done <= (state_nxt == ST_DONE);
        end
    end

    // The wait restarts on every start or sub-band step.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || state_nxt != ST_WAIT || state_r != ST_WAIT || i_start)
            cnt_r <= 16'h0000;
        else if (i_xtal_tick)
            cnt_r <= cnt_r + 16'h0001;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_band <= RST_BAND[`BS_BAND_HI:`BS_BAND_LO];
            o_sub_band <= RST_BAND[`BS_SUB_HI:`BS_SUB_LO];
        end else if (!i_enable) begin
            // Unused band code keeps the oscillator that is running.
            if (i_cfg_band != `BAND_UNUSED) o_band <= i_cfg_band;
            o_sub_band <= i_cfg_sub;
        end else if (i_start && !i_start_from_current) begin
            if (i_cfg_band != `BAND_UNUSED) o_band <= i_cfg_band;
            o_sub_band <= i_cfg_sub;
        end else if (state_r == ST_CHECK && state_nxt == ST_WAIT && !i_start) begin
            if (i_tune_code == `TUNE_LOW) o_sub_band <= o_sub_band - 4'h1;
            else o_sub_band <= o_sub_band + 4'h1;
        end
    end

    property p_wait_bound;
        @(posedge i_ref_clk) disable iff (i_srst)
        state_r == ST_WAIT |-> cnt_r < i_wait_ticks;
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("autoselect wait counter ran past its limit");

    property p_start_cfg;
        @(posedge i_ref_clk) disable iff (i_srst)
        i_enable && i_start && !i_start_from_current
            && i_cfg_band != `BAND_UNUSED
        |=> o_band == $past(i_cfg_band) && o_sub_band == $past(i_cfg_sub);
    endproperty
    a_start_cfg: assert property (p_start_cfg)
        else $error("autoselect did not start from the written band");

    c_done: cover property (@(posedge i_ref_clk) disable iff (i_srst)
        state_r == ST_CHECK ##1 state_r == ST_DONE);
endmodule : osc_autoselect
`default_nettype wire

// file: design/tuner_osc_cfg.svh
// Addresses, field positions, reset values and timing counts of the
// tuner oscillator configuration bank.
// Assumes the serial interface decodes the register address byte.
`ifndef TUNER_OSC_CFG_SVH
`define TUNER_OSC_CFG_SVH

`define TOC_ADDR_AUTOSEL 8'h01
`define TOC_ADDR_BAND 8'h02
`define TOC_ADDR_DETECT 8'h03
`define TOC_ADDR_MODE 8'h04

`define TOC_RST_AUTOSEL 8'hB3
`define TOC_RST_BAND 8'h29
`define TOC_RST_DETECT 8'h23
`define TOC_RST_MODE 8'h00

`define AS_START_BIT 6
`define AS_ENABLE_BIT 5
`define AS_PUMP_AUTO_BIT 4
`define AS_LATCH_BIT 3
`define AS_CONV_EN_BIT 2
`define AS_WAIT_HI 1
`define AS_WAIT_LO 0

`define BS_BAND_HI 6
`define BS_BAND_LO 5
`define BS_SUB_HI 4
`define BS_SUB_LO 1
`define BS_BIAS_BIT 0

`define DT_MODE_HI 7
`define DT_MODE_LO 6
`define DT_ATTACK_HI 5
`define DT_ATTACK_LO 3
`define DT_FILT_HI 2
`define DT_FILT_LO 0

`define MD_AMP_BYP_BIT 7
`define MD_FILT_BYP_BIT 6
`define MD_INJ_BIT 5

`define BAND_UNUSED 2'h3
`define SUB_MIN 4'h0
`define SUB_MAX 4'hF
`define TUNE_LOW 3'h0
`define TUNE_HIGH 3'h7

`define WAIT_CODE0 16'h3800
`define WAIT_CODE1 16'h6000
`define WAIT_CODE2 16'h8800
`define WAIT_CODE3 16'hB000
`define XTAL_DIV_DEF 3

`endif

// file: design/tuner_osc_config_regs.sv
// Register bank for oscillator autoselect, band select, detector and
// signal-path mode of the tuner, with the fields driven to the analog.
// Assumes the serial interface logic on i_ref_clk gives one-cycle write
// and read strobes with a decoded register address.
//
// Function
// - Start bit picks written band or band in use as autoselect start.
// - Autoselect enable runs the state machine; else manual band used.
// - Pump auto bit chooses automatic or manual charge-pump current.
// - Converter latch bit holds the converted value while one.
// - Converter enable bit allows reading the tuning converter.
// - Two wait bits give 14336, 24576, 34816 or 45056 crystal periods.
// - Band field picks oscillator 0, 1 or 2; code three unused.
// - Sub-band field picks one of sixteen sub-bands in binary.
// - Bias bit selects normal or low-power oscillator bias.
// - Detector mode field sets buffer output and gain loop mode.
// - Attack point field steps 2 dB from -66 dBm to -52 dBm.
// - Tracking filter field sets the filter centre, zero is minimum.
// - Mode bit 7 bypasses the third-stage variable-gain amplifier.
// - Mode bit 6 bypasses the optional RF filter.
// - Mode bit 5 selects low-side injection at one.
// - Manual pump codes give 1.5, 2, 2.5 or 3 mA.
// - Status field reports chosen pump current while automatic.
`timescale 1ns/1ps
`default_nettype none
`include "tuner_osc_cfg.svh"
module tuner_osc_config_regs
    import tuner_osc_pkg::*;
#(
    parameter int unsigned XTAL_DIV = `XTAL_DIV_DEF,
    parameter int unsigned WAIT_TICKS0 = `WAIT_CODE0,
    parameter int unsigned WAIT_TICKS1 = `WAIT_CODE1,
    parameter int unsigned WAIT_TICKS2 = `WAIT_CODE2,
    parameter int unsigned WAIT_TICKS3 = `WAIT_CODE3
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [1:0] i_pump_current_manual,
    input wire logic [2:0] i_tune_adc,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic [1:0] o_oscillator_band,
    output logic [3:0] o_current_sub_band,
    output logic o_oscillator_bias_mode,
    output logic o_autoselect_busy,
    output logic o_autoselect_done,
    output logic [1:0] o_pump_current,
    output logic [1:0] o_pump_current_readback,
    output logic [2:0] o_tuning_code,
    output logic [1:0] o_detector_buffer_mode,
    output logic [2:0] o_gain_attack_point,
    output logic [2:0] o_tracking_filter_centre,
    output logic o_third_stage_amp_bypass,
    output logic o_rf_filter_bypass,
    output logic o_injection_side_select
);
    // The tick divider and wait counters are 16 bits wide.
    if (XTAL_DIV < 1 || XTAL_DIV > 65536 || WAIT_TICKS0 < 1
        || WAIT_TICKS1 < 1 || WAIT_TICKS2 < 1 || WAIT_TICKS3 < 1
        || WAIT_TICKS0 > 65535 || WAIT_TICKS1 > 65535
        || WAIT_TICKS2 > 65535 || WAIT_TICKS3 > 65535) begin : g_bad_param
        $error("tuner_osc_config_regs: parameter out of range");
    end

    logic [7:0] autosel_r;
    logic [7:0] band_r;
    logic [7:0] detect_r;
    logic [7:0] mode_r;
    logic [15:0] xtal_cnt_r;
    logic xtal_tick_r;
    logic [15:0] wait_ticks_r;
    logic start_r;
    logic [2:0] adc_meta_r;
    logic [2:0] adc_sync_r;
    logic [2:0] adc_prev_r;
    logic [2:0] adc_code_r;
    logic wr_autosel;
    logic wr_band;
    logic pump_auto;
    localparam logic [7:0] RST_BAND = `TOC_RST_BAND;
    localparam logic [7:0] RST_DETECT = `TOC_RST_DETECT;

    assign wr_autosel = i_wr_en && i_addr == `TOC_ADDR_AUTOSEL;
    assign wr_band = i_wr_en && i_addr == `TOC_ADDR_BAND;
    assign pump_auto = autosel_r[`AS_PUMP_AUTO_BIT];

    // Factory bits are stored as written; the host owns their values.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            autosel_r <= `TOC_RST_AUTOSEL;
            band_r <= `TOC_RST_BAND;
            detect_r <= `TOC_RST_DETECT;
            mode_r <= `TOC_RST_MODE;
        end else if (i_wr_en) begin
            case (i_addr)
                `TOC_ADDR_AUTOSEL: autosel_r <= i_wr_data;
                `TOC_ADDR_BAND: band_r <= i_wr_data;
                `TOC_ADDR_DETECT: detect_r <= i_wr_data;
                `TOC_ADDR_MODE: mode_r <= i_wr_data;
                default: ;
            endcase
        end
    end

    // Addresses outside this bank answer zero; their owners answer too.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                case (i_addr)
                    `TOC_ADDR_AUTOSEL: o_rd_data <= autosel_r;
                    `TOC_ADDR_BAND: o_rd_data <= band_r;
                    `TOC_ADDR_DETECT: o_rd_data <= detect_r;
                    `TOC_ADDR_MODE: o_rd_data <= mode_r;
                    default: o_rd_data <= 8'h00;
                endcase
            end
        end
    end

    // Crystal period stand-in: one enable pulse every XTAL_DIV cycles.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            xtal_cnt_r <= 16'h0000;
            xtal_tick_r <= 1'b0;
        end else begin
            xtal_tick_r <= xtal_cnt_r == 16'(XTAL_DIV - 1);
            if (xtal_cnt_r == 16'(XTAL_DIV - 1)) xtal_cnt_r <= 16'h0000;
            else xtal_cnt_r <= xtal_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wait_ticks_r <= 16'(WAIT_TICKS3);
            start_r <= 1'b0;
        end else begin
            case (autosel_r[`AS_WAIT_HI:`AS_WAIT_LO])
                2'h0: wait_ticks_r <= 16'(WAIT_TICKS0);
                2'h1: wait_ticks_r <= 16'(WAIT_TICKS1);
                2'h2: wait_ticks_r <= 16'(WAIT_TICKS2);
                default: wait_ticks_r <= 16'(WAIT_TICKS3);
            endcase
            // A write to either steering register restarts the search.
            start_r <= wr_autosel || wr_band;
        end
    end

    // The converter code comes from analog comparators, so it is synced.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            adc_meta_r <= 3'h0;
            adc_sync_r <= 3'h0;
            adc_prev_r <= 3'h0;
            adc_code_r <= 3'h0;
        end else begin
            adc_meta_r <= i_tune_adc;
            adc_sync_r <= adc_meta_r;
            adc_prev_r <= adc_sync_r;
            // Bits may settle apart, so a code is taken once two samples agree.
            if (adc_sync_r == adc_prev_r) adc_code_r <= adc_sync_r;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst)
            o_tuning_code <= 3'h0;
        else if (!autosel_r[`AS_CONV_EN_BIT])
            o_tuning_code <= 3'h0;
        else if (!autosel_r[`AS_LATCH_BIT])
            o_tuning_code <= adc_code_r;
    end

    osc_autoselect u_autoselect (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_xtal_tick(xtal_tick_r),
        .i_enable(autosel_r[`AS_ENABLE_BIT]),
        .i_start(start_r),
        .i_start_from_current(autosel_r[`AS_START_BIT]),
        .i_cfg_band(band_r[`BS_BAND_HI:`BS_BAND_LO]),
        .i_cfg_sub(band_r[`BS_SUB_HI:`BS_SUB_LO]),
        .i_wait_ticks(wait_ticks_r),
        .i_tune_code(adc_code_r),
        .o_band(o_oscillator_band),
        .o_sub_band(o_current_sub_band),
        .o_busy(o_autoselect_busy),
        .o_done(o_autoselect_done)
    );

    // Automatic pump current grows with the sub-band in use, since upper
    // sub-bands tune with less gain; it only has effect with the converter
    // and autoselect running, which the host must arrange.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_pump_current <= 2'h0;
            o_pump_current_readback <= 2'h0;
        end else if (pump_auto) begin
            o_pump_current <= o_current_sub_band[3:2];
            o_pump_current_readback <= o_current_sub_band[3:2];
        end else begin
            o_pump_current <= i_pump_current_manual;
            o_pump_current_readback <= 2'h0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_oscillator_bias_mode <= RST_BAND[`BS_BIAS_BIT];
            o_detector_buffer_mode <= RST_DETECT[`DT_MODE_HI:`DT_MODE_LO];
            o_gain_attack_point <= RST_DETECT[`DT_ATTACK_HI:`DT_ATTACK_LO];
            o_tracking_filter_centre <= RST_DETECT[`DT_FILT_HI:`DT_FILT_LO];
            o_third_stage_amp_bypass <= 1'b0;
            o_rf_filter_bypass <= 1'b0;
            o_injection_side_select <= 1'b0;
        end else begin
            o_oscillator_bias_mode <= band_r[`BS_BIAS_BIT];
            o_detector_buffer_mode <=
                detect_r[`DT_MODE_HI:`DT_MODE_LO];
            o_gain_attack_point <=
                detect_r[`DT_ATTACK_HI:`DT_ATTACK_LO];
            o_tracking_filter_centre <=
                detect_r[`DT_FILT_HI:`DT_FILT_LO];
            o_third_stage_amp_bypass <= mode_r[`MD_AMP_BYP_BIT];
            o_rf_filter_bypass <= mode_r[`MD_FILT_BYP_BIT];
            o_injection_side_select <= mode_r[`MD_INJ_BIT];
        end
    end

    property p_write_read;
        @(posedge i_ref_clk) disable iff (i_srst)
        i_wr_en && i_addr == `TOC_ADDR_DETECT ##1
            i_rd_en && i_addr == `TOC_ADDR_DETECT && !i_wr_en
        |=> o_rd_valid && o_rd_data == $past(i_wr_data, 2);
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("register did not return the written byte");

    property p_manual_band;
        @(posedge i_ref_clk) disable iff (i_srst)
        !autosel_r[`AS_ENABLE_BIT] && $stable(band_r)
            && band_r[`BS_BAND_HI:`BS_BAND_LO] != `BAND_UNUSED
        |=> o_oscillator_band == $past(band_r[`BS_BAND_HI:`BS_BAND_LO])
            && o_current_sub_band == $past(band_r[`BS_SUB_HI:`BS_SUB_LO]);
    endproperty
    a_manual_band: assert property (p_manual_band)
        else $error("manual band or sub-band not applied");

    property p_pump_manual;
        @(posedge i_ref_clk) disable iff (i_srst)
        !pump_auto |=> o_pump_current == $past(i_pump_current_manual)
            && o_pump_current_readback == 2'h0;
    endproperty
    a_pump_manual: assert property (p_pump_manual)
        else $error("manual pump current not followed");

    property p_pump_auto;
        @(posedge i_ref_clk) disable iff (i_srst)
        pump_auto |=> o_pump_current_readback == o_pump_current;
    endproperty
    a_pump_auto: assert property (p_pump_auto)
        else $error("pump readback differs from chosen current");

    property p_latch_hold;
        @(posedge i_ref_clk) disable iff (i_srst)
        autosel_r[`AS_LATCH_BIT] && autosel_r[`AS_CONV_EN_BIT]
            ##1 autosel_r[`AS_LATCH_BIT] && autosel_r[`AS_CONV_EN_BIT]
        |=> $stable(o_tuning_code);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched converter value moved");

    property p_conv_off;
        @(posedge i_ref_clk) disable iff (i_srst)
        !autosel_r[`AS_CONV_EN_BIT] |=> o_tuning_code == 3'h0;
    endproperty
    a_conv_off: assert property (p_conv_off)
        else $error("converter read while disabled");

    property p_mode_bits;
        @(posedge i_ref_clk) disable iff (i_srst)
        i_wr_en && i_addr == `TOC_ADDR_MODE |=> ##1
            o_injection_side_select == $past(i_wr_data[`MD_INJ_BIT], 2)
            && o_rf_filter_bypass == $past(i_wr_data[`MD_FILT_BYP_BIT], 2)
            && o_third_stage_amp_bypass
                == $past(i_wr_data[`MD_AMP_BYP_BIT], 2);
    endproperty
    a_mode_bits: assert property (p_mode_bits)
        else $error("mode bits not driven two cycles after write");

    property p_detect_fields;
        @(posedge i_ref_clk) disable iff (i_srst)
        i_wr_en && i_addr == `TOC_ADDR_DETECT |=> ##1
            {o_detector_buffer_mode, o_gain_attack_point,
             o_tracking_filter_centre} == $past(i_wr_data, 2);
    endproperty
    a_detect_fields: assert property (p_detect_fields)
        else $error("detector fields not driven after write");

    property p_bias;
        @(posedge i_ref_clk) disable iff (i_srst)
        wr_band |=> ##1 o_oscillator_bias_mode
            == $past(i_wr_data[`BS_BIAS_BIT], 2);
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias mode not driven after write");

    c_auto_pump: cover property (@(posedge i_ref_clk) disable iff (i_srst)
        pump_auto && o_pump_current_readback != 2'h0);
    c_latched: cover property (@(posedge i_ref_clk) disable iff (i_srst)
        autosel_r[`AS_LATCH_BIT] && autosel_r[`AS_CONV_EN_BIT]
            && o_tuning_code != 3'h0);
    c_read: cover property (@(posedge i_ref_clk) disable iff (i_srst)
        o_rd_valid && o_rd_data == autosel_r);
endmodule : tuner_osc_config_regs
`default_nettype wire

// file: design/tuner_osc_pkg.sv
// Types shared by the tuner oscillator configuration bank.
// Assumes nothing of its surroundings.
package tuner_osc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_CHECK = 4'b0100,
        ST_DONE = 4'b1000
    } autosel_state_t;
endpackage : tuner_osc_pkg

// file: verification/host_ctrl_model.sv
// Host controller model: drives the bank's strobes as the serial interface
// does once a bus transfer has been decoded.
// Assumes the bank samples its strobes on the rising edge of i_ref_clk.
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model #(
    parameter int unsigned POWER_UP_CYCLES = 10000
) (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end

    // Released lines show the inverse of the last value, so a stale byte
    // can never pass for a fresh one.
    task automatic release_bus();
        o_addr = ~o_addr;
        o_wr_data = ~o_wr_data;
    endtask : release_bus

    task automatic power_up_wait();
        repeat (POWER_UP_CYCLES) @(posedge i_ref_clk);
    endtask : power_up_wait

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_ref_clk);
        #1;
        o_wr_en = 1'b1;
        o_addr = addr;
        o_wr_data = data;
        @(posedge i_ref_clk);
        #1;
        o_wr_en = 1'b0;
        release_bus();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                            output logic valid);
        @(posedge i_ref_clk);
        #1;
        o_rd_en = 1'b1;
        o_addr = addr;
        @(posedge i_ref_clk);
        #1;
        o_rd_en = 1'b0;
        valid = i_rd_valid;
        data = i_rd_data;
        release_bus();
    endtask : read_reg

    // Factory bits get their required values; autoselect stays off here.
    task automatic factory_init();
        write_reg(8'h01, 8'h83);
        write_reg(8'h02, 8'h29);
        write_reg(8'h04, 8'h00);
    endtask : factory_init
endmodule : host_ctrl_model
`default_nettype wire

// file: verification/test_tuner_oscillator_config_regs.sv
// Self-checking bench for the tuner oscillator configuration bank.
// Assumes the host model's tasks and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_tuner_oscillator_config_regs;
    logic i_ref_clk, i_srst, wr_en, rd_en, rd_valid, bias, busy, done;
    logic amp_byp, filt_byp, inj;
    logic [7:0] addr, wr_data, rd_data, d;
    logic [1:0] pump_man, band, pump, pump_rb, det_mode;
    logic [2:0] adc, tcode, attack, centre;
    logic [3:0] sub;
    int mismatches, total_checks, cycles, i;
    logic v;
    logic [7:0] pat [4] = '{8'h9C, 8'h7E, 8'hDA, 8'hE0};
    logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h3};

    host_ctrl_model host_u (.i_ref_clk(i_ref_clk), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wr_data(wr_data));
    tuner_osc_config_regs #(.XTAL_DIV(1), .WAIT_TICKS0(4), .WAIT_TICKS1(8),
        .WAIT_TICKS2(12), .WAIT_TICKS3(16)) dut_u (.i_ref_clk(i_ref_clk),
        .i_srst(i_srst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wr_data(wr_data), .i_pump_current_manual(pump_man),
        .i_tune_adc(adc), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_oscillator_band(band), .o_current_sub_band(sub),
        .o_oscillator_bias_mode(bias), .o_autoselect_busy(busy),
        .o_autoselect_done(done), .o_pump_current(pump),
        .o_pump_current_readback(pump_rb), .o_tuning_code(tcode),
        .o_detector_buffer_mode(det_mode), .o_gain_attack_point(attack),
        .o_tracking_filter_centre(centre), .o_third_stage_amp_bypass(amp_byp),
        .o_rf_filter_bypass(filt_byp), .o_injection_side_select(inj));

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // The whole run needs about 10200 cycles, mostly the power-up wait.
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("mismatch timeout expected 0 seen 1");
            test_done();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_u.read_reg(a, d, v);
        chk("rd_valid", 8'h01, 8'(v));
        chk("rd_data", exp, d);
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : settle

    task automatic search(input int w, input logic [1:0] b,
                          input logic [3:0] s);
        int busy_n;
        int k;
        busy_n = 0;
        for (k = 0; k < 300; k++) begin
            @(posedge i_ref_clk);
            #1;
            if (busy === 1'b1) busy_n++;
            if (k > 1 && done === 1'b1 && busy === 1'b0) break;
        end
        chk("busy_span", 8'h01, 8'(busy_n >= w && busy_n <= w + 2));
        chk("search_done", 8'h01, 8'(done));
        chk("search_band", 8'(b), 8'(band));
        chk("search_sub", 8'(s), 8'(sub));
    endtask : search

    initial begin
        i_srst = 1'b1;
        pump_man = 2'h0;
        adc = 3'h3;
        repeat (12) @(posedge i_ref_clk);
        #1;
        i_srst = 1'b0;
        rd_chk(8'h01, 8'hB3);
        rd_chk(8'h02, 8'h29);
        rd_chk(8'h03, 8'h23);
        rd_chk(8'h04, 8'h00);
        chk("band", 8'h01, 8'(band));
        chk("sub", 8'h04, 8'(sub));
        chk("attack", 8'h04, 8'(attack));
        chk("centre", 8'h03, 8'(centre));
        host_u.power_up_wait();
        host_u.factory_init();
        $display("test reset_values done");
        for (i = 0; i < 4; i++) host_u.write_reg(8'(i + 1), pat[i]);
        for (i = 0; i < 4; i++) rd_chk(8'(i + 1), pat[i]);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h05, 8'h00);
        settle(3);
        chk("band_code3", 8'h01, 8'(band));
        $display("test readback done");
        host_u.write_reg(8'h01, 8'h80);
        for (i = 0; i < 3; i++) begin
            host_u.write_reg(8'h02, {1'b0, 2'(i), 4'(i * 7), 1'(i)});
            settle(3);
            chk("band", 8'(i), 8'(band));
            chk("sub", 8'(i * 7), 8'(sub));
            chk("bias", 8'(i % 2), 8'(bias));
        end
        for (i = 0; i < 4; i++) begin
            pump_man = 2'(i);
            settle(2);
            chk("pump", 8'(i), 8'(pump));
            chk("pump_rb", 8'h00, 8'(pump_rb));
        end
        for (i = 0; i < 8; i++) begin
            host_u.write_reg(8'h03, {modes[i % 3], 3'(i), 3'(7 - i)});
            host_u.write_reg(8'h04, {3'(i), 5'h00});
            settle(2);
            chk("det_mode", 8'(modes[i % 3]), 8'(det_mode));
            chk("attack", 8'(i), 8'(attack));
            chk("centre", 8'(7 - i), 8'(centre));
            chk("mode_bits", 8'(i), 8'({amp_byp, filt_byp, inj}));
        end
        $display("test manual_fields done");
        host_u.write_reg(8'h01, 8'h84);
        adc = 3'h5;
        settle(5);
        chk("tcode", 8'h05, 8'(tcode));
        host_u.write_reg(8'h01, 8'h8C);
        adc = 3'h2;
        settle(4);
        chk("tcode_latched", 8'h05, 8'(tcode));
        host_u.write_reg(8'h01, 8'h80);
        settle(4);
        chk("tcode_off", 8'h00, 8'(tcode));
        $display("test converter done");
        adc = 3'h3;
        host_u.write_reg(8'h02, 8'h52);
        for (i = 0; i < 4; i++) begin
            host_u.write_reg(8'h01, 8'hA4 | 8'(i));
            search(4 + 4 * i, 2'h2, 4'h9);
        end
        host_u.write_reg(8'h01, 8'hE4);
        search(4, 2'h2, 4'h9);
        host_u.write_reg(8'h02, 8'h3A);
        search(4, 2'h2, 4'h9);
        host_u.write_reg(8'h01, 8'hBC);
        search(4, 2'h1, 4'hD);
        settle(2);
        chk("pump_auto", 8'h03, 8'(pump));
        chk("pump_rb", 8'h03, 8'(pump_rb));
        $display("test autoselect done");
        test_done();
    end
endmodule : test_tuner_oscillator_config_regs
`default_nettype wire
